// ==== gas_exec.sv ====
// Execution logic for dual clipped abs, 32-bit abs and halfword store,
// with the program status word reached over AXI4-Lite.
// Assumes issue logic, register file and data cache on ref_clk_in.
//
// Behaviour
// - Dual abs sign-extends each source half and takes each absolute value.
// - A half equal to 0x8000 yields 0x7FFF, keeping results in range.
// - Upper-half result goes to bits 31:16, lower-half result to 15:0.
// - 32-bit abs passes non-negatives and negates negatives, unsigned result.
// - Only guard bit 0 decides; one writes the destination, zero does not.
// - Halfword store writes source low 16 bits at base plus twice the displacement.
// - Little-endian puts bits 7:0 at base; big-endian puts bits 15:8 there.
// - An odd store address sets the misaligned store flag.
// - With trap enable set, a misaligned store requests an exception at jump.
// - A guarded-true store updates memory, and the cache when cacheable.
// - A guarded-false store has no side effects, cache state included.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "gas_defs.svh"

module gas_exec #(
	parameter int ADDR_W = 4
) (
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic                   op_valid_in,
	input  wire gas_pkg::gas_opc_type   opcode_in,
	input  wire gas_pkg::gas_slot_type  slot_in,
	input  wire gas_pkg::gas_word_type  guard_in,
	input  wire gas_pkg::gas_word_type  first_source_register_in,
	input  wire gas_pkg::gas_word_type  second_source_register_in,
	input  wire gas_pkg::gas_disp_type  disp_in,
	input  wire gas_pkg::gas_reg_type   dest_in,
	input  wire logic                   cacheable_in,
	input  wire logic                   ijmp_in,
	output logic                        alu_wr_out,
	output gas_pkg::gas_reg_type        alu_dest_out,
	output gas_pkg::gas_word_type       alu_data_out,
	output logic                        dsp_wr_out,
	output gas_pkg::gas_reg_type        dsp_dest_out,
	output gas_pkg::gas_word_type       dsp_data_out,
	output logic                        mem_wr_out,
	output logic                        cache_upd_out,
	output gas_pkg::gas_word_type       mem_addr_out,
	output logic [7:0]                  mem_byte0_out,
	output logic [7:0]                  mem_byte1_out,
	output logic                        illegal_op_out,
	output logic                        exc_req_out,
	input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire gas_pkg::gas_word_type  s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output gas_pkg::gas_resp_type       s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [ADDR_W-1:0]      s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output gas_pkg::gas_word_type       s_axi_rdata,
	output gas_pkg::gas_resp_type       s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	import gas_pkg::*;

	generate
		if (ADDR_W < 4) begin : g_bad_addr
			$error("ADDR_W must be at least 4.");
		end
	endgenerate

	// ------------------------------------------------------------------
	// Issue decode
	// ------------------------------------------------------------------
	function automatic logic slot_ok(input gas_slot_type s,
			input logic [5:0] mask);
		logic [7:0] full;
		full = {2'h0, mask};
		slot_ok = full[s];
	endfunction

	logic [2:0]   psw_ff;
	logic         pend_ff;
	wire  logic   is_dual   = opcode_in == `GAS_OPC_DUALABS;
	wire  logic   is_iabs   = opcode_in == `GAS_OPC_IABS;
	wire  logic   is_st     = opcode_in == `GAS_OPC_ST16D;
	wire  logic   dual_take = op_valid_in && is_dual &&
		slot_ok(slot_in, `GAS_SLOTS_DSPALU);
	wire  logic   iabs_take = op_valid_in && is_iabs &&
		slot_ok(slot_in, `GAS_SLOTS_ALU);
	wire  logic   st_take   = op_valid_in && is_st &&
		slot_ok(slot_in, `GAS_SLOTS_DMEM);
	wire  logic   nxt_illegal = op_valid_in && !(dual_take || iabs_take ||
		st_take);
	wire  logic   guard_true = guard_in[0];
	wire  logic   dual_fire = dual_take && guard_true;
	wire  logic   iabs_fire = iabs_take && guard_true;
	wire  logic   st_fire   = st_take && guard_true;

	// ------------------------------------------------------------------
	// Dual clipped absolute value, two stages
	// ------------------------------------------------------------------
	wire gas_word_type nxt_dual;
	genvar h;
	generate
		for (h = 0; h < 2; h++) begin : g_half
			wire logic [15:0] half = second_source_register_in[h*16 +: 16];
			wire logic [15:0] neg  = 16'(~half + 16'h0001);
			assign nxt_dual[h*16 +: 16] =
				(half == `GAS_HALF_MOST_NEG) ? `GAS_HALF_CLIP :
				half[15] ? neg : half;
		end
	endgenerate

	logic         dual_v_ff;
	gas_reg_type  dual_dest_ff;
	gas_word_type dual_res_ff;
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dual_v_ff    <= 1'b0;
			dual_dest_ff <= 7'h00;
			dual_res_ff  <= 32'h00000000;
			dsp_wr_out   <= 1'b0;
			dsp_dest_out <= 7'h00;
			dsp_data_out <= 32'h00000000;
		end else begin
			dual_v_ff    <= dual_fire;
			dual_dest_ff <= dest_in;
			dual_res_ff  <= nxt_dual;
			dsp_wr_out   <= dual_v_ff;
			dsp_dest_out <= dual_dest_ff;
			dsp_data_out <= dual_res_ff;
		end
	end

	// ------------------------------------------------------------------
	// 32-bit absolute value, one stage
	// ------------------------------------------------------------------
	wire gas_word_type nxt_iabs = second_source_register_in[31] ?
		32'(~second_source_register_in + 32'h00000001) :
		second_source_register_in;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			alu_wr_out     <= 1'b0;
			alu_dest_out   <= 7'h00;
			alu_data_out   <= 32'h00000000;
			illegal_op_out <= 1'b0;
		end else begin
			alu_wr_out     <= iabs_fire;
			alu_dest_out   <= dest_in;
			alu_data_out   <= nxt_iabs;
			illegal_op_out <= nxt_illegal;
		end
	end

	// ------------------------------------------------------------------
	// Halfword store with displacement
	// ------------------------------------------------------------------
	wire gas_word_type st_addr = 32'(second_source_register_in +
		{{24{disp_in[6]}}, disp_in, 1'b0});
	wire logic little  = psw_ff[`GAS_PSW_LITTLE_BIT];
	wire logic [7:0] nxt_b0 = little ? first_source_register_in[7:0] :
		first_source_register_in[15:8];
	wire logic [7:0] nxt_b1 = little ? first_source_register_in[15:8] :
		first_source_register_in[7:0];
	wire logic st_mis  = st_fire && st_addr[0];

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_wr_out    <= 1'b0;
			cache_upd_out <= 1'b0;
			mem_addr_out  <= 32'h00000000;
			mem_byte0_out <= 8'h00;
			mem_byte1_out <= 8'h00;
		end else begin
			mem_wr_out    <= st_fire;
			cache_upd_out <= st_fire && cacheable_in;
			if (st_fire) begin
				mem_addr_out  <= st_addr;
				mem_byte0_out <= nxt_b0;
				mem_byte1_out <= nxt_b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Status word, trap request and AXI4-Lite slave
	// ------------------------------------------------------------------
	logic              aw_got_ff;
	logic              w_got_ff;
	logic [ADDR_W-1:0] waddr_ff;
	gas_word_type      wdata_ff;
	logic              wstrb0_ff;
	wire logic aw_hs   = s_axi_awvalid && s_axi_awready;
	wire logic w_hs    = s_axi_wvalid && s_axi_wready;
	wire logic wr_go   = aw_got_ff && w_got_ff && !s_axi_bvalid;
	wire logic wr_psw  = wr_go && waddr_ff[3:0] == `GAS_PSW_OFS &&
		waddr_ff[ADDR_W-1:2] == '0 && wstrb0_ff;
	wire logic wr_hit  = waddr_ff == ADDR_W'(`GAS_PSW_OFS);
	wire logic mis_clr = wr_psw && wdata_ff[`GAS_PSW_MIS_BIT];
	wire logic [2:0] nxt_psw = {
		wr_psw ? wdata_ff[`GAS_PSW_TRAP_BIT] : psw_ff[`GAS_PSW_TRAP_BIT],
		st_mis || (psw_ff[`GAS_PSW_MIS_BIT] && !mis_clr),
		wr_psw ? wdata_ff[`GAS_PSW_LITTLE_BIT] : psw_ff[`GAS_PSW_LITTLE_BIT]};
	wire logic trap_set = st_mis && psw_ff[`GAS_PSW_TRAP_BIT];
	wire logic ar_hs   = s_axi_arvalid && s_axi_arready;
	wire logic rd_psw  = s_axi_araddr == ADDR_W'(`GAS_PSW_OFS);
	wire logic rd_stat = s_axi_araddr == ADDR_W'(`GAS_STAT_OFS);
	wire gas_word_type nxt_rdata = rd_psw ? {29'h0, psw_ff} :
		rd_stat ? {31'h0, pend_ff} : 32'h00000000;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			psw_ff      <= `GAS_PSW_RESET;
			pend_ff     <= 1'b0;
			exc_req_out <= 1'b0;
		end else begin
			psw_ff      <= nxt_psw;
			pend_ff     <= trap_set || (pend_ff && !ijmp_in);
			exc_req_out <= ijmp_in && pend_ff;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			waddr_ff      <= '0;
			wdata_ff      <= 32'h00000000;
			wstrb0_ff     <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `GAS_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_got_ff     <= 1'b1;
				waddr_ff      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_got_ff     <= 1'b1;
				wdata_ff     <= s_axi_wdata;
				wstrb0_ff    <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `GAS_RESP_OKAY : `GAS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `GAS_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= nxt_rdata;
			s_axi_rresp   <= (rd_psw || rd_stat) ? `GAS_RESP_OKAY :
				`GAS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Assertions and covers
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);

	dual_latency_a: assert property (dual_fire |-> ##2 dsp_wr_out)
		else $error("Dual abs result not written two cycles after issue.");
	dual_clip_a: assert property (
		(dual_fire && second_source_register_in[15:0] == 16'h8000) |->
		##2 dsp_data_out[15:0] == 16'h7FFF)
		else $error("Dual abs lower half not clipped.");
	dual_upper_a: assert property (
		(dual_fire && second_source_register_in[31:16] == 16'hFFFF) |->
		##2 dsp_data_out[31:16] == 16'h0001)
		else $error("Dual abs upper half misplaced.");
	dual_range_a: assert property (
		dsp_wr_out |-> !dsp_data_out[31] && !dsp_data_out[15])
		else $error("Dual abs half out of range.");
	iabs_value_a: assert property (
		iabs_fire |=> alu_wr_out && alu_data_out ==
		($past(second_source_register_in[31]) ?
		32'(-$past(second_source_register_in)) :
		$past(second_source_register_in)))
		else $error("Integer abs result wrong.");
	iabs_minneg_a: assert property (
		(iabs_fire && second_source_register_in == 32'h80000000) |=>
		alu_data_out == 32'h80000000)
		else $error("Integer abs saturated the most negative input.");
	guard_false_a: assert property (
		(op_valid_in && !guard_in[0]) |=>
		!alu_wr_out && !mem_wr_out && !cache_upd_out ##1 !dsp_wr_out)
		else $error("Guard false still caused an update.");
	store_order_a: assert property (
		st_fire |=> mem_wr_out && mem_byte0_out ==
		($past(little) ? $past(first_source_register_in[7:0]) :
		$past(first_source_register_in[15:8])))
		else $error("Store byte order wrong.");
	store_addr_a: assert property (
		st_fire |=> mem_addr_out == $past(second_source_register_in)
		+ 32'($signed($past(disp_in))) * 32'h00000002)
		else $error("Store address not base plus displacement.");
	store_slot_a: assert property (
		(op_valid_in && opcode_in == `GAS_OPC_ST16D && slot_in != 3'h4 &&
		slot_in != 3'h5) |=> !mem_wr_out && illegal_op_out)
		else $error("Store accepted outside slots four and five.");
	misalign_flag_a: assert property (
		st_mis |=> psw_ff[`GAS_PSW_MIS_BIT])
		else $error("Misaligned store flag not set.");
	trap_request_a: assert property (
		(trap_set ##1 ijmp_in) |=> exc_req_out)
		else $error("Trap not requested at interruptible jump.");

	dual_run_c: cover property (dual_fire ##2 dsp_wr_out);
	store_mis_c: cover property (st_mis ##1 ijmp_in ##1 exc_req_out);
	axi_write_c: cover property (wr_go ##[1:4] (s_axi_bvalid && s_axi_bready));
	iabs_run_c: cover property (iabs_fire ##1 alu_wr_out);
	store_skip_c: cover property (st_take && !guard_true ##1 !mem_wr_out);
endmodule

// ==== gas_defs.svh ====
// Constants of the guarded absolute value and halfword store block.
// Assumes inclusion by bare name from the design and the testbench.
`ifndef GAS_DEFS_SVH
`define GAS_DEFS_SVH

// ------------------------------------------------------------------
// Operation codes and issue slots
// ------------------------------------------------------------------
`define GAS_OPC_DUALABS     8'h48
`define GAS_OPC_IABS        8'h2C
`define GAS_OPC_ST16D       8'h1E
`define GAS_SLOTS_DSPALU    6'h0A
`define GAS_SLOTS_ALU       6'h3E
`define GAS_SLOTS_DMEM      6'h30

// ------------------------------------------------------------------
// Halfword clipping values
// ------------------------------------------------------------------
`define GAS_HALF_MOST_NEG   16'h8000
`define GAS_HALF_CLIP       16'h7FFF

// ------------------------------------------------------------------
// Register offsets, fields and reset values
// ------------------------------------------------------------------
`define GAS_PSW_OFS         4'h0
`define GAS_STAT_OFS        4'h4
`define GAS_PSW_LITTLE_BIT  0
`define GAS_PSW_MIS_BIT     1
`define GAS_PSW_TRAP_BIT    2
`define GAS_PSW_RESET       3'h0
`define GAS_RESP_OKAY       2'h0
`define GAS_RESP_SLVERR     2'h2

`endif

// ==== gas_pkg.sv ====
// Types shared by the guarded absolute value and halfword store block.
// Assumes gas_defs.svh is on the include path.
package gas_pkg;
	typedef logic [31:0] gas_word_type;
	typedef logic [7:0]  gas_opc_type;
	typedef logic [2:0]  gas_slot_type;
	typedef logic [6:0]  gas_reg_type;
	typedef logic [6:0]  gas_disp_type;
	typedef logic [1:0]  gas_resp_type;
endpackage

// ==== gas_far_model.sv ====
// Far-side model: register file and byte memory fed by the write strobes.
// Assumes the execution block's result and store ports on one clock.
`timescale 1ns/1ps

module gas_far_model (
	input  wire logic                  ref_clk_in,
	input  wire logic                  alu_wr_in,
	input  wire gas_pkg::gas_reg_type  alu_dest_in,
	input  wire gas_pkg::gas_word_type alu_data_in,
	input  wire logic                  dsp_wr_in,
	input  wire gas_pkg::gas_reg_type  dsp_dest_in,
	input  wire gas_pkg::gas_word_type dsp_data_in,
	input  wire logic                  mem_wr_in,
	input  wire gas_pkg::gas_word_type mem_addr_in,
	input  wire logic [7:0]            mem_byte0_in,
	input  wire logic [7:0]            mem_byte1_in
);
	import gas_pkg::*;
	gas_word_type regs_ff [128];
	logic [7:0]   mem_ff  [4096];

	// Results and stored bytes land on their strobes.
	always_ff @(posedge ref_clk_in) begin
		if (alu_wr_in)
			regs_ff[alu_dest_in] <= alu_data_in;
		if (dsp_wr_in)
			regs_ff[dsp_dest_in] <= dsp_data_in;
		if (mem_wr_in) begin
			mem_ff[mem_addr_in[11:0]] <= mem_byte0_in;
			mem_ff[mem_addr_in[11:0] + 12'h001] <= mem_byte1_in;
		end
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the guarded abs and halfword store block.
// Assumes gas_pkg, gas_exec and gas_far_model are compiled first.
`timescale 1ns/1ps
`include "gas_defs.svh"

module testbench;
	import gas_pkg::*;
	logic         ref_clk_in, rst_b_in, op_valid_in, cacheable_in, ijmp_in;
	logic         alu_wr_out, dsp_wr_out, mem_wr_out, cache_upd_out;
	logic         illegal_op_out, exc_req_out;
	gas_opc_type  opcode_in;
	gas_slot_type slot_in;
	gas_disp_type disp_in;
	gas_reg_type  dest_in, alu_dest_out, dsp_dest_out;
	gas_word_type guard_in, first_source_register_in;
	gas_word_type second_source_register_in, alu_data_out, dsp_data_out;
	gas_word_type mem_addr_out, s_axi_wdata, s_axi_rdata;
	gas_resp_type s_axi_bresp, s_axi_rresp;
	logic [7:0]   mem_byte0_out, mem_byte1_out;
	logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic         s_axi_rvalid, s_axi_rready;
	int           n_mismatch = 0;
	int           check_count = 0;

	gas_exec #(.ADDR_W(4)) gas_exec_i (.*);
	gas_far_model gas_far_model_i (.ref_clk_in(ref_clk_in),
		.alu_wr_in(alu_wr_out), .alu_dest_in(alu_dest_out),
		.alu_data_in(alu_data_out), .dsp_wr_in(dsp_wr_out),
		.dsp_dest_in(dsp_dest_out), .dsp_data_in(dsp_data_out),
		.mem_wr_in(mem_wr_out), .mem_addr_in(mem_addr_out),
		.mem_byte0_in(mem_byte0_out), .mem_byte1_in(mem_byte1_out));

	task automatic results();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic tmo();
		n_mismatch++;
		$display("CHECK FAILED at %0t: wait timed out", $time);
		results();
	endtask

	task automatic issue(input gas_opc_type op, input gas_slot_type sl,
			input gas_word_type g, s1, s2, input gas_disp_type d);
		@(posedge ref_clk_in);
		op_valid_in <= 1'b1;
		opcode_in <= op;
		slot_in <= sl;
		guard_in <= g;
		first_source_register_in <= s1;
		second_source_register_in <= s2;
		disp_in <= d;
		dest_in <= {3'h1, s2[3:0]};
		@(posedge ref_clk_in);
		op_valid_in <= 1'b0;
		#1;
	endtask

	task automatic axw(input logic [3:0] a, input gas_word_type d,
			input logic [3:0] s, output gas_resp_type r);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (++n > 50) tmo();
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a, output gas_word_type d,
			output gas_resp_type r);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk_in);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (++n > 50) tmo();
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_axi();
		gas_word_type d;
		gas_resp_type r;
		axr(4'h0, d, r);
		chk(d[2:0] === `GAS_PSW_RESET && r === `GAS_RESP_OKAY, "psw reset");
		axw(4'h0, 32'h5, 4'hE, r);
		axr(4'h0, d, r);
		chk(d[2:0] === 3'h0, "strobe ignored");
		axr(4'h8, d, r);
		chk(r === `GAS_RESP_SLVERR, "unmapped read");
		axw(4'h8, 32'h1, 4'hF, r);
		chk(r === `GAS_RESP_SLVERR, "unmapped write");
	endtask

	task automatic t_iabs();
		gas_word_type iv [4] = '{32'hFFFFFFF4, 32'h80000000, 32'h80000001, 1};
		gas_word_type ev [4] = '{32'hC, 32'h80000000, 32'h7FFFFFFF, 1};
		for (int i = 0; i < 5; i++) begin
			issue(`GAS_OPC_IABS, 3'(i + 1), 1, 0, iv[i % 4], 0);
			chk(alu_wr_out === 1'b1 && alu_data_out === ev[i % 4], "abs");
			chk(alu_dest_out === {3'h1, iv[i % 4][3:0]}, "abs dest");
		end
		issue(`GAS_OPC_IABS, 3'h2, 32'hFFFFFFFE, 0, 32'h5, 0);
		chk(alu_wr_out === 1'b0, "abs guard");
	endtask

	task automatic t_dual();
		gas_word_type iv [5] = '{32'hFFFF0032, 32'h80008001, 32'h0032FFFF,
			32'h7FFFFFFF, 32'hFFFF8000};
		gas_word_type ev [5] = '{32'h00010032, 32'h7FFF7FFF, 32'h00320001,
			32'h7FFF0001, 32'h00017FFF};
		for (int i = 0; i < 6; i++) begin
			issue(`GAS_OPC_DUALABS, i[0] ? 3'h3 : 3'h1, i < 5, 0, iv[i % 5], 0);
			chk(dsp_wr_out === 1'b0, "dual early");
			@(posedge ref_clk_in);
			#1;
			chk(dsp_wr_out === (i < 5), "dual strobe");
			if (i < 5) chk(dsp_data_out === ev[i], "dual");
			if (i < 5) chk(dsp_dest_out === {3'h1, iv[i][3:0]}, "dual dest");
		end
		issue(`GAS_OPC_DUALABS, 3'h2, 1, 0, iv[0], 0);
		chk(illegal_op_out === 1'b1, "dual slot");
	endtask

	task automatic t_store();
		gas_word_type d;
		gas_resp_type r;
		@(posedge ref_clk_in);
		cacheable_in <= 1'b1;
		issue(`GAS_OPC_ST16D, 3'h4, 1, 32'h44332211, 32'hCFE, 7'h01);
		chk(mem_wr_out === 1'b1 && mem_addr_out === 32'hD00, "addr");
		chk(mem_byte0_out === 8'h22 && mem_byte1_out === 8'h11, "big");
		chk(cache_upd_out === 1'b1, "cache");
		issue(`GAS_OPC_ST16D, 3'h5, 3, 32'hAABBCCDD, 32'hD06, 7'h7E);
		chk(mem_addr_out === 32'hD02 && mem_byte0_out === 8'hCC, "neg");
		@(posedge ref_clk_in);
		#1;
		chk(gas_far_model_i.mem_ff[12'hD03] === 8'hDD, "memory");
		axw(4'h0, 32'h1, 4'hF, r);
		issue(`GAS_OPC_ST16D, 3'h4, 1, 32'h44332211, 32'hCFE, 7'h01);
		chk(mem_byte0_out === 8'h11 && mem_byte1_out === 8'h22, "little");
		issue(`GAS_OPC_ST16D, 3'h4, 2, 32'h1234, 32'hD05, 7'h7E);
		chk(mem_wr_out === 1'b0 && cache_upd_out === 1'b0, "guard");
		axr(4'h0, d, r);
		chk(d[1] === 1'b0, "no flag");
		cacheable_in <= 1'b0;
		issue(`GAS_OPC_ST16D, 3'h1, 1, 32'h1234, 32'hD00, 0);
		chk(mem_wr_out === 1'b0 && illegal_op_out === 1'b1, "slot");
	endtask

	task automatic t_mis();
		gas_word_type d;
		gas_resp_type r;
		axw(4'h0, 32'h4, 4'hF, r);
		issue(`GAS_OPC_ST16D, 3'h5, 1, 32'h55AA, 32'hD01, 0);
		chk(mem_wr_out === 1'b1 && cache_upd_out === 1'b0, "uncached");
		axr(4'h0, d, r);
		chk(d[2:0] === 3'h6, "flag");
		axr(4'h4, d, r);
		chk(d[0] === 1'b1, "pending");
		for (int i = 1; i >= 0; i--) begin
			@(posedge ref_clk_in);
			ijmp_in <= 1'b1;
			@(posedge ref_clk_in);
			ijmp_in <= 1'b0;
			#1;
			chk(exc_req_out === i[0], "exception");
		end
		@(posedge ref_clk_in);
		op_valid_in <= 1'b1;
		second_source_register_in <= 32'h00000D03;
		@(posedge ref_clk_in);
		op_valid_in <= 1'b0;
		ijmp_in <= 1'b1;
		@(posedge ref_clk_in);
		ijmp_in <= 1'b0;
		#1;
		chk(exc_req_out === 1'b1, "jump after store");
		axw(4'h0, 32'h2, 4'hF, r);
		axr(4'h0, d, r);
		chk(d[2:0] === 3'h0, "flag clear");
	endtask

	task automatic t_reset();
		gas_word_type d;
		gas_resp_type r;
		axw(4'h0, 32'h5, 4'hF, r);
		chk(r === `GAS_RESP_OKAY, "psw write");
		@(posedge ref_clk_in);
		rst_b_in <= 1'b0;
		issue(`GAS_OPC_IABS, 3'h1, 1, 0, 32'h5, 0);
		chk({alu_wr_out, dsp_wr_out, mem_wr_out, exc_req_out, illegal_op_out,
			s_axi_bvalid, s_axi_rvalid} === 7'h00, "reset strobes");
		chk({s_axi_awready, s_axi_wready, s_axi_arready} === 3'h7,
			"reset ready");
		repeat (8) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		axr(4'h0, d, r);
		chk(d[2:0] === `GAS_PSW_RESET, "psw after reset");
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #2 ref_clk_in = ~ref_clk_in;
	end

	initial begin
		rst_b_in = 1'b0;
		{op_valid_in, opcode_in, slot_in, guard_in, disp_in, dest_in} = '0;
		{first_source_register_in, second_source_register_in} = '0;
		{cacheable_in, ijmp_in, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wdata} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		repeat (10) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		t_axi();
		t_iabs();
		t_dual();
		t_store();
		t_mis();
		t_reset();
		results();
	end
endmodule
